/* design/node_switch_config_regs.sv */
// Node configuration register bank with direction-table routing lookup.
`timescale 1ns/1ps

module node_switch_config_regs #(
	parameter logic [7:0]  SWITCH_REVISION = 8'h00,
	parameter logic [7:0]  SWITCH_VERSION  = 8'h00,
	parameter int          LINK_COUNT      = 8,
	parameter int          SWITCH_PROCS    = 2,
	parameter int          DEVICE_PROCS    = 2,
	// Arbitrary neutral identity values.
	parameter logic [31:0] JTAG_ID_VALUE   = 32'h0000_0001,
	// Arbitrary neutral identity value.
	parameter logic [31:0] USER_CODE_VALUE = 32'h0000_0000,
	parameter logic [31:0] PLL_RESET       = 32'h0000_0000
) (
	input  wire logic                    sys_clk,
	input  wire logic                    rst,
	input  wire logic [7:0]              boot_control_pins,
	input  wire node_cfg_pkg::cfg_req_t  cfg_req,
	output logic [31:0]                  cfg_rdata,
	output logic                         cfg_rvalid,
	input  wire node_cfg_pkg::route_req_t route_req,
	output logic [3:0]                   route_direction,
	output logic                         route_local,
	output logic                         route_done,
	output logic                         one_byte_headers,
	output logic [15:0]                  node_id,
	output node_cfg_pkg::pll_t           pll_setting,
	output logic                         pll_bypass,
	output logic                         boot_from_jtag,
	output logic                         pll_wait_relock,
	output logic                         tile_reset,
	output logic                         chip_reset,
	output logic [15:0]                  switch_clk_ratio,
	output logic [15:0]                  ref_clk_ratio
);
	import node_cfg_pkg::*;

	// Counts must fit their eight-bit fields.
	if (LINK_COUNT < 0 || LINK_COUNT > 255 || SWITCH_PROCS < 0 ||
		SWITCH_PROCS > 255 || DEVICE_PROCS < 0 || DEVICE_PROCS > 255)
	begin : g_bad_counts
		$error("Processor or link count does not fit eight bits.");
	end

	// Stored register state.
	logic [7:0]   boot_snapshot;
	switch_cfg_t  sw_cfg;
	logic [31:0]  node_identifier;
	pll_t         pll_settings;
	logic [31:0]  switch_clock_divider;
	logic [31:0]  reference_clock_divider;
	logic [31:0]  route_directions_low;
	logic [31:0]  route_directions_high;
	logic [31:0]  spare_register_a;
	logic [31:0]  spare_register_b;

	// Read-only words assembled from parameters and the snapshot.
	node_identity_t node_identity;
	switch_desc_t   switch_description;
	jtag_id_t       jtag_identity_copy;
	user_code_t     user_code_copy;

	assign node_identity = '{rsvd: 8'h00, boot: boot_snapshot,
		revision: SWITCH_REVISION, version: SWITCH_VERSION};
	assign switch_description = '{rsvd: 8'h00, links: LINK_COUNT[7:0],
		switch_procs: SWITCH_PROCS[7:0], device_procs: DEVICE_PROCS[7:0]};
	assign jtag_identity_copy = jtag_id_t'(JTAG_ID_VALUE);
	assign user_code_copy = user_code_t'(USER_CODE_VALUE);

	// Register number decode.
	wire hit_identity = (cfg_req.num == REG_NODE_IDENTITY);
	wire hit_desc     = (cfg_req.num == REG_SWITCH_DESC);
	wire hit_cfg      = (cfg_req.num == REG_SWITCH_CONFIG);
	wire hit_nodeid   = (cfg_req.num == REG_NODE_IDENTIFIER);
	wire hit_pll      = (cfg_req.num == REG_PLL_SETTINGS);
	wire hit_swdiv    = (cfg_req.num == REG_SWITCH_CLK_DIV);
	wire hit_refdiv   = (cfg_req.num == REG_REF_CLK_DIV);
	wire hit_jtag     = (cfg_req.num == REG_JTAG_ID_COPY);
	wire hit_user     = (cfg_req.num == REG_USER_CODE_COPY);
	wire hit_dirlo    = (cfg_req.num == REG_ROUTE_DIR_LOW);
	wire hit_dirhi    = (cfg_req.num == REG_ROUTE_DIR_HIGH);
	wire hit_spa      = (cfg_req.num == REG_SPARE_A);
	wire hit_spb      = (cfg_req.num == REG_SPARE_B);

	// control write lock
	// The lock also covers its own register, so it holds until reset.
	wire wr_ok = cfg_req.wr & ~sw_cfg.lock_ctl;
	wire wr_pll = wr_ok & hit_pll & ~sw_cfg.lock_pll;
	wire [31:0] wdata = cfg_req.wdata;
	wire pll_t  pll_new = pll_t'(wdata & PLL_WMASK);

	// boot pin snapshot
	// The pins are sampled on every reset cycle and frozen at release.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			boot_snapshot <= boot_control_pins;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			sw_cfg <= switch_cfg_t'(ZERO_WORD);
		else if (wr_ok && hit_cfg)
			sw_cfg <= switch_cfg_t'(wdata & SWCFG_WMASK);
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			node_identifier <= ZERO_WORD;
		else if (wr_ok && hit_nodeid)
			node_identifier <= wdata & HALF_WMASK;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			pll_settings <= pll_t'(PLL_RESET & PLL_WMASK);
		else if (wr_pll)
			pll_settings <= pll_new;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			tile_reset      <= 1'b0;
			chip_reset      <= 1'b0;
			pll_wait_relock <= 1'b0;
		end
		else
		begin
			tile_reset      <= wr_pll;
			chip_reset      <= wr_pll & ~pll_new.keep_chip;
			pll_wait_relock <= wr_pll & ~pll_new.no_relock_wait;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			switch_clock_divider    <= ZERO_WORD;
			reference_clock_divider <= REFCLK_RESET;
		end
		else
		begin
			if (wr_ok && hit_swdiv)
				switch_clock_divider <= wdata & HALF_WMASK;
			if (wr_ok && hit_refdiv)
				reference_clock_divider <= wdata & HALF_WMASK;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			route_directions_low  <= ZERO_WORD;
			route_directions_high <= ZERO_WORD;
		end
		else
		begin
			if (wr_ok && hit_dirlo)
				route_directions_low <= wdata;
			if (wr_ok && hit_dirhi)
				route_directions_high <= wdata;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			spare_register_a <= ZERO_WORD;
			spare_register_b <= ZERO_WORD;
		end
		else
		begin
			if (wr_ok && hit_spa)
				spare_register_a <= wdata & SPARE_WMASK;
			if (wr_ok && hit_spb)
				spare_register_b <= wdata & SPARE_WMASK;
		end
	end

	// numbered read select
	// Unmapped numbers read as zero rather than raising an error.
	logic [31:0] next_rdata;
	assign next_rdata =
		hit_identity ? 32'(node_identity) :
		hit_desc     ? 32'(switch_description) :
		hit_cfg      ? 32'(sw_cfg) :
		hit_nodeid   ? node_identifier :
		hit_pll      ? 32'(pll_settings) :
		hit_swdiv    ? switch_clock_divider :
		hit_refdiv   ? reference_clock_divider :
		hit_jtag     ? 32'(jtag_identity_copy) :
		hit_user     ? 32'(user_code_copy) :
		hit_dirlo    ? route_directions_low :
		hit_dirhi    ? route_directions_high :
		hit_spa      ? spare_register_a :
		hit_spb      ? spare_register_b : ZERO_WORD;

	// Read data is registered one cycle after the request.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			cfg_rdata  <= ZERO_WORD;
			cfg_rvalid <= 1'b0;
		end
		else
		begin
			cfg_rvalid <= cfg_req.rd;
			if (cfg_req.rd)
				cfg_rdata <= next_rdata;
		end
	end

	// Highest differing bit picks the dimension.
	function automatic logic [3:0] top_bit(input logic [15:0] diff);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 0; i < 16; i++)
			if (diff[i])
				idx = 4'(i);
		return idx;
	endfunction : top_bit

	wire [15:0] id_diff   = route_req.dest ^ node_identifier[15:0];
	wire [3:0]  dimension = top_bit(id_diff);
	wire [63:0] dir_table = {route_directions_high, route_directions_low};
	wire [3:0]  next_dir  = dir_table[{dimension, 2'b00} +: DIR_WIDTH];

	// local delivery
	// A matching packet reports direction zero and raises the local flag.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			route_direction <= 4'h0;
			route_local     <= 1'b0;
			route_done      <= 1'b0;
		end
		else
		begin
			route_done <= route_req.valid;
			if (route_req.valid)
			begin
				route_local     <= (id_diff == 16'h0000);
				route_direction <= (id_diff == 16'h0000) ? 4'h0 : next_dir;
			end
		end
	end

	// bypass and boot source follow stored bits.
	assign pll_bypass       = pll_settings.bypass;
	assign boot_from_jtag   = pll_settings.boot_jtag;
	assign pll_setting      = pll_settings;
	assign one_byte_headers = sw_cfg.one_byte_hdr;
	assign node_id          = node_identifier[15:0];
	assign switch_clk_ratio = switch_clock_divider[15:0];
	assign ref_clk_ratio    = reference_clock_divider[15:0];

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence pll_wr_s;
		cfg_req.wr && hit_pll && !sw_cfg.lock_ctl && !sw_cfg.lock_pll;
	endsequence

	sequence cfg_wr_s(logic hit);
		cfg_req.wr && hit && !sw_cfg.lock_ctl;
	endsequence

	// snapshot frozen
	// The first edge after release still holds the last reset capture.
	a_boot_frozen: assert property (!$past(rst) |->
		$stable(boot_snapshot))
		else $error("Boot snapshot changed outside reset.");
	a_identity_read: assert property (cfg_req.rd && hit_identity |=>
		cfg_rvalid && cfg_rdata == {8'h00, boot_snapshot,
		SWITCH_REVISION, SWITCH_VERSION})
		else $error("Identity read returned wrong word.");
	a_desc_read: assert property (cfg_req.rd && hit_desc |=>
		cfg_rdata == {8'h00, LINK_COUNT[7:0], SWITCH_PROCS[7:0],
		DEVICE_PROCS[7:0]})
		else $error("Description read returned wrong counts.");
	a_ctl_locked: assert property (sw_cfg.lock_ctl && cfg_req.wr
		|=> $stable(node_identifier) && $stable(route_directions_low))
		else $error("Locked register changed on write.");
	a_pll_locked: assert property (sw_cfg.lock_pll && cfg_req.wr &&
		hit_pll |=> $stable(pll_settings) && !tile_reset)
		else $error("Locked PLL settings accepted a write.");
	a_hdr_mode: assert property (cfg_wr_s(hit_cfg) |=>
		one_byte_headers == $past(cfg_req.wdata[0]))
		else $error("Header mode did not follow write.");
	a_node_id: assert property (cfg_wr_s(hit_nodeid) |=>
		node_identifier == {16'h0000, $past(cfg_req.wdata[15:0])})
		else $error("Node identifier write wrong.");
	a_tile_reset: assert property (pll_wr_s ##1 !wr_pll |->
		tile_reset ##1 !tile_reset)
		else $error("Tile reset was not a single pulse.");
	a_chip_keep: assert property (pll_wr_s ##0 cfg_req.wdata[31]
		|=> !chip_reset && tile_reset)
		else $error("Chip reset raised despite keep bit.");
	a_relock_skip: assert property (pll_wr_s ##0 cfg_req.wdata[30]
		|=> !pll_wait_relock)
		else $error("Relock wait requested despite skip bit.");
	a_bypass_set: assert property (pll_wr_s ##0 cfg_req.wdata[29]
		|=> pll_bypass)
		else $error("PLL bypass not applied.");
	a_jtag_boot: assert property (pll_wr_s ##0 cfg_req.wdata[28]
		|=> boot_from_jtag)
		else $error("JTAG boot mode not applied.");
	a_pll_fields: assert property (pll_wr_s |=>
		pll_settings.fb_mult == $past(cfg_req.wdata[20:8]))
		else $error("Feedback multiplier not stored.");
	a_refclk_reset: assert property ($fell(rst) |->
		ref_clk_ratio == 16'h0003 && switch_clk_ratio == 16'h0000)
		else $error("Clock divider reset values wrong.");
	a_route_dim0: assert property (route_req.valid &&
		id_diff == 16'h0001 |=> route_done &&
		route_direction == $past(route_directions_low[3:0]))
		else $error("Dimension zero route wrong.");
	a_route_dim15: assert property (route_req.valid &&
		id_diff[15] |=> route_direction == $past(route_directions_high[31:28]))
		else $error("Dimension fifteen route wrong.");
	a_route_local: assert property (route_req.valid &&
		id_diff == 16'h0000 |=> route_local && route_done)
		else $error("Matching packet not delivered locally.");
	a_spare_zero: assert property (cfg_req.rd && (hit_spa || hit_spb)
		|=> cfg_rdata[31:2] == 30'h0)
		else $error("Spare reserved bits read nonzero.");

endmodule : node_switch_config_regs

/* include/node_cfg_pkg.sv */
// Constants, field layouts and carriers for the node configuration bank.
package node_cfg_pkg;

	// Register numbers used by configuration reads and writes.
	localparam logic [7:0] REG_NODE_IDENTITY   = 8'h00;
	localparam logic [7:0] REG_SWITCH_DESC     = 8'h01;
	localparam logic [7:0] REG_SWITCH_CONFIG   = 8'h04;
	localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
	localparam logic [7:0] REG_PLL_SETTINGS    = 8'h06;
	localparam logic [7:0] REG_SWITCH_CLK_DIV  = 8'h07;
	localparam logic [7:0] REG_REF_CLK_DIV     = 8'h08;
	localparam logic [7:0] REG_JTAG_ID_COPY    = 8'h09;
	localparam logic [7:0] REG_USER_CODE_COPY  = 8'h0A;
	localparam logic [7:0] REG_ROUTE_DIR_LOW   = 8'h0C;
	localparam logic [7:0] REG_ROUTE_DIR_HIGH  = 8'h0D;
	localparam logic [7:0] REG_SPARE_A         = 8'h10;
	localparam logic [7:0] REG_SPARE_B         = 8'h11;

	// Writable bits of each register and the reset values.
	localparam logic [31:0] SWCFG_WMASK   = 32'h8000_0101;
	localparam logic [31:0] HALF_WMASK    = 32'h0000_FFFF;
	localparam logic [31:0] PLL_WMASK     = 32'hF39F_FF7F;
	localparam logic [31:0] SPARE_WMASK   = 32'h0000_0003;
	localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
	localparam logic [31:0] REFCLK_RESET  = 32'h0000_0003;
	localparam logic [31:0] PLL_RESET_VAL = 32'h0000_0000;
	localparam logic [3:0]  DIR_WIDTH     = 4'h4;

	// Configuration request from the access port.
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  num;
		logic [31:0] wdata;
	} cfg_req_t;

	// Identification layout.
	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] boot;
		logic [7:0] revision;
		logic [7:0] version;
	} node_identity_t;

	// Switch description layout.
	typedef struct packed {
		logic [7:0] rsvd;
		logic [7:0] links;
		logic [7:0] switch_procs;
		logic [7:0] device_procs;
	} switch_desc_t;

	// Switch configuration layout.
	typedef struct packed {
		logic        lock_ctl;
		logic [21:0] rsvd_hi;
		logic        lock_pll;
		logic [6:0]  rsvd_lo;
		logic        one_byte_hdr;
	} switch_cfg_t;

	// PLL settings layout.
	typedef struct packed {
		logic        keep_chip;
		logic        no_relock_wait;
		logic        bypass;
		logic        boot_jtag;
		logic [1:0]  rsvd_a;
		logic [2:0]  pll_output_divider;
		logic [1:0]  rsvd_b;
		logic [12:0] fb_mult;
		logic        rsvd_c;
		logic [6:0]  in_div;
	} pll_t;

	// Identity copies.
	typedef struct packed {
		logic [3:0]  version;
		logic [15:0] part;
		logic [10:0] maker;
		logic        one;
	} jtag_id_t;

	typedef struct packed {
		logic [13:0] otp_code;
		logic [17:0] metal_code;
	} user_code_t;

	// Routing lookup request.
	typedef struct packed {
		logic        valid;
		logic [15:0] dest;
	} route_req_t;

endpackage : node_cfg_pkg

/* tb/test_node_switch_config_regs.sv */
// Self-checking bench for the node configuration register bank.
`timescale 1ns/1ps

module test_node_switch_config_regs;
	import node_cfg_pkg::*;

	localparam logic [7:0]  REV   = 8'h5A;
	localparam logic [7:0]  VER   = 8'h3C;
	// Arbitrary identity values, chosen only to be recognisable.
	localparam logic [31:0] JTAG  = 32'h1234_5671;
	localparam logic [31:0] UCODE = 32'h0ABC_DEF0;
	localparam logic [7:0]  RW_NUM [7] = '{8'h05, 8'h07, 8'h08, 8'h0C,
		8'h0D, 8'h10, 8'h11};
	localparam logic [31:0] RW_MASK [7] = '{HALF_WMASK, HALF_WMASK,
		HALF_WMASK, 32'hFFFF_FFFF, 32'hFFFF_FFFF, SPARE_WMASK, SPARE_WMASK};
	localparam logic [15:0] CORNER [4] = '{16'h0000, 16'h8000, 16'h0001,
		16'h0180};

	logic        sys_clk;
	logic        rst;
	logic [7:0]  boot_control_pins;
	cfg_req_t    cfg_req;
	logic [31:0] cfg_rdata;
	logic        cfg_rvalid;
	route_req_t  route_req;
	logic [3:0]  route_direction;
	logic        route_local;
	logic        route_done;
	logic        one_byte_headers;
	logic [15:0] node_id;
	pll_t        pll_setting;
	logic        pll_bypass;
	logic        boot_from_jtag;
	logic        pll_wait_relock;
	logic        tile_reset;
	logic        chip_reset;
	logic [15:0] switch_clk_ratio;
	logic [15:0] ref_clk_ratio;
	int          failures;
	int          samples_checked;
	integer      seed;
	logic [31:0] word;
	logic [31:0] pll_prev;
	logic [31:0] rw_exp [7];
	logic [15:0] id_exp;
	logic [63:0] dir_tbl;

	node_switch_config_regs #(
		.SWITCH_REVISION (REV),
		.SWITCH_VERSION  (VER),
		.LINK_COUNT      (6),
		.SWITCH_PROCS    (3),
		.DEVICE_PROCS    (5),
		.JTAG_ID_VALUE   (JTAG),
		.USER_CODE_VALUE (UCODE)
	) uut (
		.sys_clk           (sys_clk),
		.rst               (rst),
		.boot_control_pins (boot_control_pins),
		.cfg_req           (cfg_req),
		.cfg_rdata         (cfg_rdata),
		.cfg_rvalid        (cfg_rvalid),
		.route_req         (route_req),
		.route_direction   (route_direction),
		.route_local       (route_local),
		.route_done        (route_done),
		.one_byte_headers  (one_byte_headers),
		.node_id           (node_id),
		.pll_setting       (pll_setting),
		.pll_bypass        (pll_bypass),
		.boot_from_jtag    (boot_from_jtag),
		.pll_wait_relock   (pll_wait_relock),
		.tile_reset        (tile_reset),
		.chip_reset        (chip_reset),
		.switch_clk_ratio  (switch_clk_ratio),
		.ref_clk_ratio     (ref_clk_ratio)
	);

	// Free-running 50 MHz clock.
	initial sys_clk = 1'b0;
	always #10 sys_clk = ~sys_clk;

	task automatic finish_test();
		if (failures == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : finish_test

	task automatic check(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : check

	// Each access idles one cycle first so no strobe is set twice at once.
	task automatic wr(input logic [7:0] num, input logic [31:0] data);
		@(posedge sys_clk);
		#1;
		cfg_req.wr    = 1'b1;
		cfg_req.num   = num;
		cfg_req.wdata = data;
		@(posedge sys_clk);
		#1;
		cfg_req.wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] num, input logic [31:0] exp,
		input string name);
		@(posedge sys_clk);
		#1;
		cfg_req.rd  = 1'b1;
		cfg_req.num = num;
		@(posedge sys_clk);
		#1;
		cfg_req.rd = 1'b0;
		check("cfg_rvalid", 32'h1, {31'h0, cfg_rvalid});
		check(name, exp, cfg_rdata);
	endtask : rd

	// Highest differing bit wins because later hits overwrite earlier ones.
	function automatic logic [3:0] exp_dir(input logic [15:0] d);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++)
			if (d[i] !== id_exp[i])
				r = dir_tbl[4*i +: 4];
		return r;
	endfunction : exp_dir

	task automatic route(input logic [15:0] d);
		@(posedge sys_clk);
		#1;
		route_req.valid = 1'b1;
		route_req.dest  = d;
		@(posedge sys_clk);
		#1;
		route_req.valid = 1'b0;
		check("route_done", 32'h1, {31'h0, route_done});
		check("route_local", {31'h0, d === id_exp}, {31'h0, route_local});
		check("route_direction", {28'h0, exp_dir(d)}, {28'h0, route_direction});
	endtask : route

	// Cuts a hang short well beyond the few hundred cycles the run needs.
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		failures++;
		finish_test();
	end

	initial
	begin
		cfg_req = '0;
		route_req = '0;
		rst = 1'b1;
		boot_control_pins = 8'hA5;
		seed = 9;
		failures = 0;
		samples_checked = 0;
		repeat (5) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		// Reset values, identity words and unmapped numbers.
		rd(REG_NODE_IDENTITY, {8'h00, 8'hA5, REV, VER}, "identity");
		rd(REG_SWITCH_DESC, 32'h0006_0305, "description");
		rd(REG_SWITCH_CONFIG, ZERO_WORD, "config");
		rd(REG_PLL_SETTINGS, ZERO_WORD, "pll");
		rd(REG_JTAG_ID_COPY, JTAG, "jtag_copy");
		rd(REG_USER_CODE_COPY, UCODE, "user_code");
		for (int k = 0; k < 7; k++)
			rd(RW_NUM[k], (k == 2) ? REFCLK_RESET : ZERO_WORD, "rw_reset");
		check("ref_clk_ratio", 32'h3, {16'h0, ref_clk_ratio});
		rd(8'h02, ZERO_WORD, "unmapped");
		rd(8'h1F, ZERO_WORD, "unmapped");
		// Writes to read-only places are ignored.
		wr(REG_NODE_IDENTITY, 32'hFFFF_FFFF);
		wr(REG_USER_CODE_COPY, 32'hFFFF_FFFF);
		rd(REG_NODE_IDENTITY, {8'h00, 8'hA5, REV, VER}, "identity_ro");
		rd(REG_USER_CODE_COPY, UCODE, "user_code_ro");
		// Random words into every writable register except config and PLL, read back masked.
		for (int k = 0; k < 7; k++)
		begin
			word = $random(seed);
			rw_exp[k] = word & RW_MASK[k];
			wr(RW_NUM[k], word);
			rd(RW_NUM[k], rw_exp[k], "rw_readback");
		end
		check("node_id", rw_exp[0], {16'h0, node_id});
		check("switch_clk_ratio", rw_exp[1], {16'h0, switch_clk_ratio});
		check("ref_clk_ratio", rw_exp[2], {16'h0, ref_clk_ratio});
		id_exp = rw_exp[0][15:0];
		dir_tbl = {rw_exp[4], rw_exp[3]};
		// Header size follows config bit 0 both ways.
		wr(REG_SWITCH_CONFIG, 32'h7FFF_FEFF);
		check("one_byte_headers", 32'h1, {31'h0, one_byte_headers});
		rd(REG_SWITCH_CONFIG, 32'h0000_0001, "config");
		wr(REG_SWITCH_CONFIG, ZERO_WORD);
		check("one_byte_headers", 32'h0, {31'h0, one_byte_headers});
		// Every combination of the two PLL control bits.
		for (int k = 0; k < 4; k++)
		begin
			word = $random(seed);
			word[31:30] = k[1:0];
			wr(REG_PLL_SETTINGS, word);
			check("tile_reset", 32'h1, {31'h0, tile_reset});
			check("chip_reset", {31'h0, ~word[31]}, {31'h0, chip_reset});
			check("pll_wait_relock", {31'h0, ~word[30]}, {31'h0, pll_wait_relock});
			check("pll_bypass", {31'h0, word[29]}, {31'h0, pll_bypass});
			check("boot_from_jtag", {31'h0, word[28]}, {31'h0, boot_from_jtag});
			check("pll_setting", word & PLL_WMASK, pll_setting);
			rd(REG_PLL_SETTINGS, word & PLL_WMASK, "pll");
			check("tile_reset", 32'h0, {31'h0, tile_reset});
		end
		// PLL lock refuses PLL writes but leaves other registers open.
		pll_prev = word & PLL_WMASK;
		wr(REG_SWITCH_CONFIG, 32'h0000_0100);
		wr(REG_PLL_SETTINGS, ~word);
		check("tile_reset", 32'h0, {31'h0, tile_reset});
		rd(REG_PLL_SETTINGS, pll_prev, "pll_locked");
		wr(REG_SWITCH_CLK_DIV, 32'h0000_1234);
		rd(REG_SWITCH_CLK_DIV, 32'h0000_1234, "clk_div");
		wr(REG_SWITCH_CONFIG, ZERO_WORD);
		wr(REG_PLL_SETTINGS, 32'h0000_0000);
		check("tile_reset", 32'h1, {31'h0, tile_reset});
		// Route lookups: corners first, then random destinations.
		for (int k = 0; k < 44; k++)
			route((k < 4) ? id_exp ^ CORNER[k] : 16'($random(seed)));
		// Global lock freezes every register, itself included.
		wr(REG_SWITCH_CONFIG, 32'h8000_0001);
		wr(REG_NODE_IDENTIFIER, {16'h0, ~id_exp});
		rd(REG_NODE_IDENTIFIER, {16'h0, id_exp}, "node_locked");
		wr(REG_SWITCH_CONFIG, ZERO_WORD);
		rd(REG_SWITCH_CONFIG, 32'h8000_0001, "config_locked");
		// A second reset clears the lock and takes new boot pin levels.
		@(posedge sys_clk);
		#1;
		rst = 1'b1;
		boot_control_pins = 8'h3C;
		repeat (2) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		rd(REG_NODE_IDENTITY, {8'h00, 8'h3C, REV, VER}, "identity");
		rd(REG_SWITCH_CONFIG, ZERO_WORD, "config");
		rd(REG_NODE_IDENTIFIER, ZERO_WORD, "node_identifier");
		finish_test();
	end

endmodule : test_node_switch_config_regs
